// ==== design/adcc_consts.svh ====
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// result and field widths
`define ADCC_RES_W        10
`define ADCC_CHS_W        6
`define ADCC_CHS_MSB      7
`define ADCC_CHS_LSB      2
`define ADCC_POSITIVE_REFERENCE_SELECT_W       2
`define ADCC_CS_W         3
`define ADCC_TRIG_W       3
`define ADCC_TRIG_N       8
`define ADCC_DIV_W        6
`define ADCC_BIT_W        4

// left-justified low byte keeps two result bits at its top
`define ADCC_LJ_PAD       6
// software readback with left format is shifted by this many places
`define ADCC_SW_SHIFT     4

// clock select codes; x11 picks the dedicated rc clock
`define ADCC_CS_RC_LOW    2'b11

// one instruction is four system clocks at 50 MHz (80 ns)
`define ADCC_CLK_NS       20
`define ADCC_INSTR_NS     80
`define ADCC_INSTR_CYC    ((`ADCC_INSTR_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

// reset values
`define ADCC_RESULT_RST   16'h0000
`define ADCC_TRIG_OFF     3'h0

`endif

// ==== design/adcc_pkg.sv ====
package adcc_pkg;

    typedef enum logic [2:0] {
        ADCC_IDLE,
        ADCC_RC_WAIT,
        ADCC_SAMPLE,
        ADCC_CONVERT
    } adcc_state_e;

    // the result register pair as software sees it
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } adcc_pair_s;

    // interrupt enables that decide the wake behaviour
    typedef struct packed {
        logic conv;
        logic periph;
        logic global_en;
    } adcc_irq_en_s;

endpackage

// ==== design/adcc_top.sv ====
`timescale 1ns/1ps
`include "adcc_consts.svh"
// What this block does
// R1: pin is converted whatever its analog-select setting; no such input exists here.
// R2: channel select routes the chosen input to sample-and-hold for next conversion.
// R3: software waits an acquisition delay after changing channel before starting.
// R4: software discharges hold capacitor via ground channel, aborting after acquisition.
// R5: positive reference select picks the converter's positive reference source.
// R6: three-bit clock select picks system clock divide 2..64 or rc clock.
// R7: each result bit resolves in one period of the selected conversion clock.
// R8: control logic runs off selected clock; rc selection delays control writes.
// R9: done flag sets at every conversion end, irq enable or not.
// R10: interrupt event raised when done sets while conversion irq enabled.
// R11: software clears done flag; hardware never clears it.
// R12: converter keeps running in sleep only with rc clock selected.
// R13: sleep completion with global enable 0 wakes core without service routine.
// R14: sleep completion with all enables set wakes core, then vectors.
// R15: ten-bit result shown left or right justified per format select.
// R16: software writes store right-justified; left format readback shifts four places.
// R17: converter is active only while its enable bit is set.
// R18: conversion starts on software start write or selected external trigger.
// R19: software never sets start in the same write that enables converter.
// R20: completion clears start, sets done flag, loads result pair.
// R21: rising edge of selected trigger source sets the start bit.
// R22: rc clock selected delays conversion start by one extra instruction.
// R23: sleep with non-rc clock aborts conversion, turns converter off, enable kept.
// R24: channel select is six bits, bits seven to two of first control register.
// R25: left format: upper eight bits in high byte, low two atop low byte.
module adcc_top (
    input  wire logic                          clk_sys,
    input  wire logic                          arst_n,
    input  wire logic                          enable,
    input  wire logic [7:0]                    control0,
    input  wire logic [`ADCC_POSITIVE_REFERENCE_SELECT_W-1:0]       positive_reference_select,
    input  wire logic [`ADCC_CS_W-1:0]         clock_select,
    input  wire logic                          result_format_select,
    input  wire logic                          start_set,
    input  wire logic                          start_clear,
    input  wire logic [`ADCC_TRIG_W-1:0]       trigger_source_select,
    input  wire logic [`ADCC_TRIG_N-1:0]       trigger_inputs,
    input  wire logic                          dedicated_rc_clock,
    input  wire logic                          sleep,
    input  wire adcc_pkg::adcc_irq_en_s        irq_en,
    input  wire logic                          done_clear,
    input  wire logic                          result_wr_hi,
    input  wire logic                          result_wr_lo,
    input  wire logic [7:0]                    result_wr_data,
    input  wire logic                          comparator_above,
    output logic                               start_bit,
    output logic                               conversion_done_flag,
    output logic                               irq_event,
    output logic                               wake_core,
    output logic                               vector_isr,
    output adcc_pkg::adcc_pair_s               result_register_pair,
    output logic [`ADCC_CHS_W-1:0]             sampled_channel,
    output logic [`ADCC_POSITIVE_REFERENCE_SELECT_W-1:0]            reference_route,
    output logic                               sample_hold,
    output logic [`ADCC_RES_W-1:0]             sar_trial,
    output logic                               converter_powered
);

    logic                         rst_meta_n;
    logic                         rst_n;
    adcc_pkg::adcc_state_e        state;
    logic [`ADCC_DIV_W-1:0]       div_cnt;
    logic [`ADCC_DIV_W-1:0]       div_mask;
    logic                         rc_sel;
    logic                         conv_tick;
    logic [2:0]                   instr_cnt;
    logic [`ADCC_BIT_W-1:0]       bit_idx;
    logic [`ADCC_RES_W-1:0]       sar_value;
    logic [15:0]                  pair_store;
    logic                         sw_written;
    logic                         trig_sel;
    logic                         trig_prev;
    logic                         trig_pending;
    logic                         start_req;
    logic                         start_sync;
    logic                         complete;
    logic                         halt_sleep;
    logic                         abort;
    logic [`ADCC_CHS_W-1:0]       channel_select;

    // reset released through two flops; the asserted edge stays asynchronous
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    assign channel_select = control0[`ADCC_CHS_MSB:`ADCC_CHS_LSB]; // see R24

    // clock select decode: {cs[1:0],cs[2]} is the divide exponent minus one
    assign rc_sel   = (clock_select[1:0] == `ADCC_CS_RC_LOW); // see R6
    always_comb begin
        div_mask = '0;
        case ({clock_select[1:0], clock_select[2]})
            3'h0: div_mask = 6'h01; // see R6
            3'h1: div_mask = 6'h03;
            3'h2: div_mask = 6'h07;
            3'h3: div_mask = 6'h0f;
            3'h4: div_mask = 6'h1f;
            3'h5: div_mask = 6'h3f;
            default: div_mask = 6'h01;
        endcase
    end

    // free-running divider; the rc strobe is taken as a synchronous tick
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    assign conv_tick = rc_sel ? dedicated_rc_clock
                              : ((div_cnt & div_mask) == div_mask); // see R7

    // sleep without the rc clock stops the converter but leaves enable alone
    assign halt_sleep        = sleep && !rc_sel; // see R12
    assign converter_powered = enable && !halt_sleep; // see R17
    assign abort             = !enable || halt_sleep || start_clear; // see R23

    // external trigger edge detect
    assign trig_sel = (trigger_source_select != `ADCC_TRIG_OFF)
                      && trigger_inputs[trigger_source_select];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_sel;
        end
    end

    // a trigger in sleep is held until the converter may run again
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trig_pending <= 1'b0;
        end else if (!enable) begin
            trig_pending <= 1'b0;
        end else if (trig_sel && !trig_prev && halt_sleep) begin
            trig_pending <= 1'b1;
        end else if (!halt_sleep) begin
            trig_pending <= 1'b0;
        end
    end

    assign start_req = enable && !halt_sleep
                       && (start_set // see R18
                           || (trig_sel && !trig_prev) // see R21
                           || trig_pending);

    // start bit: completion or abort clears it, a fresh request wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            start_bit <= 1'b0;
        end else if (start_req) begin
            start_bit <= 1'b1;
        end else if (complete || abort) begin
            start_bit <= 1'b0; // see R20
        end
    end

    // with the rc clock the start is only seen on an rc edge, a sync delay
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            start_sync <= 1'b0;
        end else if (!start_bit || abort) begin
            start_sync <= 1'b0;
        end else if (!rc_sel || conv_tick) begin
            start_sync <= 1'b1; // see R8
        end
    end

    assign complete = (state == adcc_pkg::ADCC_CONVERT) && conv_tick
                      && (bit_idx == '0) && !abort;

    // sequencer: optional instruction wait, one sample period, ten bit periods
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state     <= adcc_pkg::ADCC_IDLE;
            instr_cnt <= '0;
            bit_idx   <= '0;
            sar_value <= '0;
        end else if (abort) begin
            state <= adcc_pkg::ADCC_IDLE; // see R23
        end else begin
            case (state)
                adcc_pkg::ADCC_IDLE: begin
                    instr_cnt <= '0;
                    if (start_sync && start_bit) begin
                        state <= rc_sel ? adcc_pkg::ADCC_RC_WAIT
                                        : adcc_pkg::ADCC_SAMPLE;
                    end
                end
                adcc_pkg::ADCC_RC_WAIT: begin
                    instr_cnt <= instr_cnt + 3'h1;
                    if (instr_cnt == 3'(`ADCC_INSTR_CYC - 1)) begin
                        state <= adcc_pkg::ADCC_SAMPLE; // see R22
                    end
                end
                adcc_pkg::ADCC_SAMPLE: begin
                    if (conv_tick) begin
                        state     <= adcc_pkg::ADCC_CONVERT;
                        bit_idx   <= 4'(`ADCC_RES_W - 1);
                        sar_value <= '0;
                    end
                end
                adcc_pkg::ADCC_CONVERT: begin
                    if (conv_tick) begin
                        sar_value[bit_idx] <= comparator_above; // see R7
                        if (bit_idx == '0) begin
                            state <= adcc_pkg::ADCC_IDLE;
                        end else begin
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end
                end
                default: state <= adcc_pkg::ADCC_IDLE;
            endcase
        end
    end

    // channel and reference routed to the analog side; latched at start
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sampled_channel <= '0;
            reference_route <= '0;
        end else if (state == adcc_pkg::ADCC_IDLE) begin
            sampled_channel <= channel_select; // see R2
            reference_route <= positive_reference_select; // see R5
        end
    end

    // the analog mux ignores any pin analog-select setting
    assign sample_hold = (state == adcc_pkg::ADCC_SAMPLE); // see R1

    // trial word offered to the comparator: decided bits plus current trial bit
    always_comb begin
        sar_trial = sar_value;
        if (state == adcc_pkg::ADCC_CONVERT) begin
            sar_trial[bit_idx] = 1'b1;
        end
    end

    // done flag: set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conversion_done_flag <= 1'b0;
        end else if (complete) begin
            conversion_done_flag <= 1'b1; // see R9
        end else if (done_clear) begin
            conversion_done_flag <= 1'b0; // see R11
        end
    end

    // interrupt and wake pulses, one cycle after completion
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_event  <= 1'b0;
            wake_core  <= 1'b0;
            vector_isr <= 1'b0;
        end else begin
            irq_event  <= complete && irq_en.conv; // see R10
            wake_core  <= complete && sleep && irq_en.conv && irq_en.periph; // see R13
            vector_isr <= complete && sleep && irq_en.conv && irq_en.periph
                          && irq_en.global_en; // see R14
        end
    end

    // stored pair: conversions load formatted, software bytes land right-justified
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pair_store <= `ADCC_RESULT_RST;
            sw_written <= 1'b0;
        end else if (complete) begin
            sw_written <= 1'b0;
            if (result_format_select) begin
                pair_store <= {6'h00, sar_value[9:1], comparator_above}; // see R15
            end else begin
                pair_store <= {sar_value[9:1], comparator_above,
                               {`ADCC_LJ_PAD{1'b0}}}; // see R25
            end
        end else if (result_wr_hi || result_wr_lo) begin
            sw_written <= 1'b1; // see R16
            if (result_wr_hi) begin
                pair_store[15:8] <= result_wr_data;
            end
            if (result_wr_lo) begin
                pair_store[7:0] <= result_wr_data;
            end
        end
    end

    // readback view; software-written data shows shifted under left format
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_register_pair <= `ADCC_RESULT_RST;
        end else if (sw_written && !result_format_select) begin
            result_register_pair <= {pair_store[15-`ADCC_SW_SHIFT:0],
                                     {`ADCC_SW_SHIFT{1'b0}}}; // see R16
        end else begin
            result_register_pair <= pair_store;
        end
    end

endmodule

// ==== tb/adcc_props.sv ====
`timescale 1ns/1ps
module adcc_props (
    input wire logic                   clk_sys,
    input wire logic                   arst_n,
    input wire logic                   enable,
    input wire logic [2:0]             clock_select,
    input wire logic                   start_set,
    input wire logic                   sleep,
    input wire adcc_pkg::adcc_irq_en_s irq_en,
    input wire logic                   done_clear,
    input wire logic                   start_bit,
    input wire logic                   conversion_done_flag,
    input wire logic                   irq_event,
    input wire logic                   converter_powered,
    input wire logic                   sample_hold,
    input wire logic [5:0]             sampled_channel
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // codes ending in 11 pick the rc clock, the only one that survives sleep
    wire rc_sel = (clock_select[1:0] == 2'b11);

    // taking requests and refusing them
    a_start_taken: assert property (start_set && enable
        && !(sleep && !rc_sel) |=> start_bit)
        else $error("start request not taken");
    a_off_no_start: assert property (!enable |=> !start_bit)
        else $error("start bit set while disabled");
    a_sleep_abort: assert property (sleep && !rc_sel |=> !start_bit)
        else $error("conversion kept running in sleep");
    a_power_rule: assert property (converter_powered
        == (enable && !(sleep && !rc_sel)))
        else $error("converter power state wrong");
    // completion side effects
    a_done_stop: assert property ($rose(conversion_done_flag) |-> !start_bit)
        else $error("start bit left set at completion");
    a_done_sticky: assert property (conversion_done_flag
        && !done_clear |=> conversion_done_flag)
        else $error("done flag cleared by hardware");
    a_irq_raise: assert property ($rose(conversion_done_flag)
        && $past(irq_en.conv) |-> irq_event)
        else $error("no interrupt event at completion");
    a_irq_cause: assert property (irq_event
        |-> conversion_done_flag && $past(irq_en.conv))
        else $error("interrupt event without cause");
    // channel must not move while the input is held
    a_chan_hold: assert property (sample_hold && $past(sample_hold)
        |-> $stable(sampled_channel))
        else $error("channel changed during sampling");
    // eleven ticks of a two-clock period bound the fastest conversion
    a_div2_time: assert property ($rose(start_bit)
        && clock_select == 3'b000 |-> ##[14:34] !start_bit)
        else $error("divide by two conversion too long");
endmodule

// ==== tb/adcc_top_tb.sv ====
`timescale 1ns/1ps
bind adcc_top adcc_props u_adcc_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .enable(enable), .clock_select(clock_select),
    .start_set(start_set), .sleep(sleep), .irq_en(irq_en), .done_clear(done_clear),
    .start_bit(start_bit), .conversion_done_flag(conversion_done_flag),
    .irq_event(irq_event), .converter_powered(converter_powered),
    .sample_hold(sample_hold), .sampled_channel(sampled_channel)
);
module adcc_top_tb;
    logic        clk_sys, arst_n, enable, result_format_select, start_set, start_clear;
    logic        dedicated_rc_clock, sleep, done_clear, result_wr_hi, result_wr_lo;
    logic        comparator_above, start_bit, conversion_done_flag, irq_event, wake_core;
    logic        vector_isr, sample_hold, converter_powered;
    logic [7:0]  control0, trigger_inputs, result_wr_data;
    logic [1:0]  positive_reference_select, reference_route;
    logic [2:0]  clock_select, trigger_source_select;
    logic [5:0]  sampled_channel;
    logic [9:0]  sar_trial, vin;
    logic [31:0] seed;
    adcc_pkg::adcc_irq_en_s irq_en;
    adcc_pkg::adcc_pair_s   result_register_pair;
    int          err_count, num_checks, cyc, n_irq, n_wake, n_vec;
    int          rc_cnt = 0;
    logic [2:0]  cs_tab [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int          div_tab [8] = '{2, 4, 8, 16, 32, 64, 8, 8};

    adcc_top u_adcc_top (
        .clk_sys(clk_sys), .arst_n(arst_n), .enable(enable), .control0(control0),
        .positive_reference_select(positive_reference_select), .clock_select(clock_select),
        .result_format_select(result_format_select), .start_set(start_set),
        .start_clear(start_clear), .trigger_source_select(trigger_source_select),
        .trigger_inputs(trigger_inputs), .dedicated_rc_clock(dedicated_rc_clock),
        .sleep(sleep), .irq_en(irq_en), .done_clear(done_clear),
        .result_wr_hi(result_wr_hi), .result_wr_lo(result_wr_lo),
        .result_wr_data(result_wr_data), .comparator_above(comparator_above),
        .start_bit(start_bit), .conversion_done_flag(conversion_done_flag),
        .irq_event(irq_event), .wake_core(wake_core), .vector_isr(vector_isr),
        .result_register_pair(result_register_pair), .sampled_channel(sampled_channel),
        .reference_route(reference_route), .sample_hold(sample_hold),
        .sar_trial(sar_trial), .converter_powered(converter_powered)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // analog model: input at or above the trial word; settled before the next edge
    always @(negedge clk_sys) comparator_above <= (sar_trial <= vin);
    // rc strobe every eight clocks, free running like an oscillator
    always @(negedge clk_sys) begin
        rc_cnt <= (rc_cnt == 7) ? 0 : rc_cnt + 1;
        dedicated_rc_clock <= (rc_cnt == 7);
    end
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // every step also counts the pulse outputs
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            n_irq += (irq_event === 1'b1);
            n_wake += (wake_core === 1'b1);
            n_vec += (vector_isr === 1'b1);
        end
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // one conversion with random input, channel, reference, format and irq enable
    task automatic run_conv(input logic [2:0] cs, input int n, input int k,
                            input logic sl, input logic global_irq_enable);
        int t;
        logic ie;
        seed = xs(seed);
        ie = seed[21] | sl;
        {result_format_select, positive_reference_select, control0, vin} = seed[20:0];
        clock_select = cs;
        irq_en = '{ie, sl, global_irq_enable};
        done_clear = 1'b1;
        tick(1);
        done_clear = 1'b0;
        tick(6); // settle after channel change
        n_irq = 0;
        n_wake = 0;
        n_vec = 0;
        if (k == 0) start_set = 1'b1;
        else trigger_inputs[k] = 1'b1;
        tick(1);
        start_set = 1'b0;
        sleep = sl;
        for (t = 1; t < 2000 && conversion_done_flag !== 1'b1; t++) tick(1);
        chk(16'(t >= 10 * n && t <= 12 * n + 16), 16'h1);
        tick(6);
        sleep = 1'b0;
        trigger_inputs = 8'h00;
        chk(result_register_pair,
            result_format_select ? {6'h00, vin} : {vin, 6'h00});
        chk(16'(start_bit), 16'h0);
        chk(16'(conversion_done_flag), 16'h1);
        chk(16'(sampled_channel), 16'(control0[7:2]));
        chk(16'(reference_route), 16'(positive_reference_select));
        chk(16'(n_irq), 16'(ie));
        if (sl) chk(16'({n_wake != 0, n_vec != 0}), 16'({1'b1, global_irq_enable}));
    endtask
    // slow conversion stopped midway by a clear or by sleep on a system clock
    task automatic run_abort(input logic by_sleep);
        clock_select = 3'b110;
        done_clear = 1'b1;
        start_set = 1'b1;
        tick(1);
        {done_clear, start_set} = 2'b00;
        tick(40);
        if (by_sleep) sleep = 1'b1;
        else start_clear = 1'b1;
        tick(1);
        start_clear = 1'b0;
        tick(2);
        chk(16'({start_bit, converter_powered}), 16'({1'b0, !by_sleep}));
        tick(800);
        chk(16'(conversion_done_flag), 16'h0);
        sleep = 1'b0;
    endtask

    initial begin
        {arst_n, enable, result_format_select, start_set, start_clear, sleep} = '0;
        {done_clear, result_wr_hi, result_wr_lo} = '0;
        {control0, trigger_inputs, result_wr_data, positive_reference_select} = '0;
        {clock_select, trigger_source_select, irq_en, vin} = '0;
        {err_count, num_checks} = '0;
        seed = 32'h4112;
        tick(10);
        arst_n = 1'b1;
        tick(5);
        start_set = 1'b1;
        tick(1);
        start_set = 1'b0;
        tick(3);
        chk(16'(start_bit), 16'h0);
        enable = 1'b1;
        tick(4); // enable lands before any start
        for (int i = 0; i < 8; i++) run_conv(cs_tab[i], div_tab[i], 0, 1'b0, 1'b0);
        for (int k = 1; k < 8; k++) begin
            trigger_source_select = k[2:0];
            trigger_inputs[k % 7 + 1] = 1'b1;
            tick(3);
            chk(16'(start_bit), 16'h0); // unselected source ignored
            trigger_inputs = 8'h00;
            tick(1);
            run_conv(3'b000, 2, k, 1'b0, 1'b0);
        end
        trigger_source_select = 3'h0;
        for (int g = 0; g < 2; g++) run_conv(3'b011, 8, 0, 1'b1, g[0]);
        // start then abort is also the software discharge sequence
        run_abort(1'b0);
        run_abort(1'b1);
        // a trigger edge seen in sleep is held and starts once awake
        {trigger_source_select, sleep} = {3'h1, 1'b1};
        trigger_inputs[1] = 1'b1;
        tick(3);
        chk(16'(start_bit), 16'h0);
        sleep = 1'b0;
        tick(2);
        chk(16'(start_bit), 16'h1);
        {start_clear, trigger_inputs, trigger_source_select} = {1'b1, 8'h00, 3'h0};
        tick(1);
        start_clear = 1'b0;
        tick(2);
        chk(16'(start_bit), 16'h0);
        for (int f = 0; f < 2; f++) begin
            seed = xs(seed);
            result_format_select = f[0];
            {result_wr_data, result_wr_hi} = {seed[7:0], 1'b1};
            tick(1);
            {result_wr_data, result_wr_hi, result_wr_lo} = {seed[15:8], 2'b01};
            tick(1);
            result_wr_lo = 1'b0;
            tick(2);
            chk(result_register_pair, {seed[7:0], seed[15:8]} << (f ? 0 : 4));
        end
        give_verdict();
    end
endmodule
